// ===== rtl/exiv_regs.svh
// Register offsets, field positions, reset values and vector addresses of the interrupt block.
`ifndef EXIV_REGS_SVH
`define EXIV_REGS_SVH
`define EXIV_OFF_CTRL 8'h00
`define EXIV_OFF_ENABLE 8'h04
`define EXIV_OFF_FLAG 8'h08
`define EXIV_OFF_MASK 8'h0C
`define EXIV_OFF_ISTAT 8'h10
`define EXIV_OFF_IMASK 8'h14
`define EXIV_OFF_PINS 8'h18
`define EXIV_CTRL_SENSE_LOW 0
`define EXIV_CTRL_SENSE_HIGH 1
`define EXIV_CTRL_GIE 2
`define EXIV_EN_EXT 6
`define EXIV_EN_PC 5
`define EXIV_FLAG_EXT 6
`define EXIV_FLAG_PC 5
`define EXIV_NUM_PC 6
`define EXIV_VEC_RESET 4'h0
`define EXIV_VEC_EXT 4'h1
`define EXIV_VEC_PC 4'h2
`define EXIV_VEC_T1_CMPA 4'h3
`define EXIV_VEC_T1_OVF 4'h4
`define EXIV_VEC_T0_OVF 4'h5
`define EXIV_VEC_EEPROM 4'h6
`define EXIV_VEC_COMP 4'h7
`define EXIV_VEC_ADC 4'h8
`define EXIV_VEC_T1_CMPB 4'h9
`define EXIV_VEC_T0_CMPA 4'hA
`define EXIV_VEC_T0_CMPB 4'hB
`define EXIV_VEC_WDT 4'hC
`define EXIV_VEC_SER_START 4'hD
`define EXIV_VEC_SER_OVF 4'hE
`define EXIV_RESET_CTRL 8'h00
`endif

// ===== rtl/exiv_pkg.sv
// Types shared by the interrupt block modules.
package exiv_pkg;
  typedef enum logic [1:0] {
    EXIV_SENSE_LOW,
    EXIV_SENSE_ANY,
    EXIV_SENSE_FALL,
    EXIV_SENSE_RISE
  } exiv_sense_t;
  typedef enum logic [1:0] {
    EXIV_BUS_IDLE,
    EXIV_BUS_ACK
  } exiv_bus_t;
endpackage

// ===== rtl/exiv_det_if.sv
// Detector signals passed between the controller and its edge detector.
interface exiv_det_if;
  logic ext_pin;
  logic [5:0] pc_pins;
  logic [5:0] pc_mask;
  logic [1:0] sense;
  logic ext_event;
  logic ext_level;
  logic pc_event;
  modport ctrl (output ext_pin, output pc_pins, output pc_mask, output sense,
    input ext_event, input ext_level, input pc_event);
  modport det (input ext_pin, input pc_pins, input pc_mask, input sense,
    output ext_event, output ext_level, output pc_event);
endinterface

// ===== rtl/exiv_detect.sv
// Pin sampler that finds external pin edges, low levels and masked pin changes.
`include "exiv_regs.svh"
module exiv_detect
  import exiv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  exiv_det_if.det det
);
  typedef struct packed {
    logic ext_prev;
    logic [5:0] pc_prev;
  } exiv_det_state_t;
  exiv_det_state_t st_r;
  exiv_det_state_t st_nxt;
  logic [5:0] pc_hit;

  // Each pin compares its sample with the previous one under its mask bit.
  genvar gi;
  generate
    for (gi = 0; gi < `EXIV_NUM_PC; gi++) begin : g_pc
      assign pc_hit[gi] = det.pc_mask[gi] & (det.pc_pins[gi] ^ st_r.pc_prev[gi]);
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    st_nxt.ext_prev = det.ext_pin;
    st_nxt.pc_prev = det.pc_pins;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= '{ext_prev: 1'b1, pc_prev: 6'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pulses lasting one clock or more are caught by the sample compare.
  always_comb begin
    det.ext_event = 1'b0;
    case (exiv_sense_t'(det.sense))
      EXIV_SENSE_ANY: det.ext_event = det.ext_pin ^ st_r.ext_prev;
      EXIV_SENSE_FALL: det.ext_event = ~det.ext_pin & st_r.ext_prev;
      EXIV_SENSE_RISE: det.ext_event = det.ext_pin & ~st_r.ext_prev;
      default: det.ext_event = 1'b0;
    endcase
  end
  assign det.ext_level = (exiv_sense_t'(det.sense) == EXIV_SENSE_LOW) & ~det.ext_pin;
  assign det.pc_event = |pc_hit;
endmodule

// ===== rtl/exiv_ctrl.sv
// Interrupt vector controller with external pin and pin-change sources.
//
// Added by the designer: the register offsets and the Wishbone slave port.
`include "exiv_regs.svh"
module exiv_ctrl
  import exiv_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic ext_irq_pin,
  input wire logic [5:0] pin_change_inputs,
  input wire logic irq_taken,
  input wire logic [3:0] irq_taken_vector,
  output logic irq_req,
  output logic [3:0] irq_vector,
  output logic irq_out
);
  typedef struct packed {
    exiv_bus_t bus;
    logic [31:0] dat;
    logic err;
    logic [7:0] core_control_reg;
    logic ext_en;
    logic pc_en;
    logic ext_irq_flag;
    logic pin_change_flag;
    logic [5:0] pin_change_mask;
    logic [1:0] istat;
    logic [1:0] imask;
    logic req;
    logic [3:0] vec;
    logic irq;
  } exiv_state_t;
  exiv_state_t st_r;
  exiv_state_t st_nxt;
  exiv_det_if det_bus ();
  logic bus_req;
  logic wr;
  logic rd;
  logic mapped;
  logic [1:0] sense;
  logic ext_pending;
  logic pc_pending;
  logic gie;

  assign det_bus.ext_pin = ext_irq_pin;
  assign det_bus.pc_pins = pin_change_inputs;
  assign det_bus.pc_mask = st_r.pin_change_mask;
  assign det_bus.sense = sense;

  exiv_detect u_detect (
    .sys_clk(sys_clk),
    .reset(reset),
    .det(det_bus)
  );

  assign sense = {st_r.core_control_reg[`EXIV_CTRL_SENSE_HIGH],
    st_r.core_control_reg[`EXIV_CTRL_SENSE_LOW]};
  assign gie = st_r.core_control_reg[`EXIV_CTRL_GIE];
  assign bus_req = wb_cyc_i & wb_stb_i & (st_r.bus == EXIV_BUS_IDLE);
  assign wr = bus_req & wb_we_i & wb_sel_i[0];
  assign rd = bus_req & ~wb_we_i;
  assign mapped = (wb_adr_i == `EXIV_OFF_CTRL) | (wb_adr_i == `EXIV_OFF_ENABLE) |
    (wb_adr_i == `EXIV_OFF_FLAG) | (wb_adr_i == `EXIV_OFF_MASK) |
    (wb_adr_i == `EXIV_OFF_ISTAT) | (wb_adr_i == `EXIV_OFF_IMASK) |
    (wb_adr_i == `EXIV_OFF_PINS);
  // Low level asks directly; edge modes ask through the flag.
  assign ext_pending = (det_bus.ext_level | st_r.ext_irq_flag) & st_r.ext_en;
  assign pc_pending = st_r.pin_change_flag & st_r.pc_en;

  always_comb begin
    st_nxt = st_r;
    st_nxt.bus = EXIV_BUS_IDLE;
    st_nxt.dat = 32'h0000_0000;
    st_nxt.err = 1'b0;
    if (bus_req) begin
      st_nxt.bus = EXIV_BUS_ACK;
      st_nxt.err = ~mapped;
    end
    // Hardware clears on handler entry or write-one; a new event wins afterwards.
    if (irq_taken && irq_taken_vector == `EXIV_VEC_EXT) begin
      st_nxt.ext_irq_flag = 1'b0;
    end
    if (irq_taken && irq_taken_vector == `EXIV_VEC_PC) begin
      st_nxt.pin_change_flag = 1'b0;
    end
    if (wr) begin
      case (wb_adr_i)
        `EXIV_OFF_CTRL: st_nxt.core_control_reg = wb_dat_i[7:0];
        `EXIV_OFF_ENABLE: begin
          st_nxt.ext_en = wb_dat_i[`EXIV_EN_EXT];
          st_nxt.pc_en = wb_dat_i[`EXIV_EN_PC];
        end
        `EXIV_OFF_FLAG: begin
          if (wb_dat_i[`EXIV_FLAG_EXT]) begin
            st_nxt.ext_irq_flag = 1'b0;
          end
          if (wb_dat_i[`EXIV_FLAG_PC]) begin
            st_nxt.pin_change_flag = 1'b0;
          end
        end
        `EXIV_OFF_MASK: st_nxt.pin_change_mask = wb_dat_i[5:0];
        `EXIV_OFF_IMASK: st_nxt.imask = wb_dat_i[1:0];
        default: st_nxt.core_control_reg = st_r.core_control_reg;
      endcase
    end
    if (rd) begin
      case (wb_adr_i)
        `EXIV_OFF_CTRL: st_nxt.dat = {24'h000000, st_r.core_control_reg};
        `EXIV_OFF_ENABLE: begin
          st_nxt.dat[`EXIV_EN_EXT] = st_r.ext_en;
          st_nxt.dat[`EXIV_EN_PC] = st_r.pc_en;
        end
        `EXIV_OFF_FLAG: begin
          st_nxt.dat[`EXIV_FLAG_EXT] = st_r.ext_irq_flag;
          st_nxt.dat[`EXIV_FLAG_PC] = st_r.pin_change_flag;
        end
        `EXIV_OFF_MASK: st_nxt.dat = {26'h0000000, st_r.pin_change_mask};
        `EXIV_OFF_ISTAT: begin
          st_nxt.dat = {30'h0, st_r.istat};
          st_nxt.istat = 2'h0;
        end
        `EXIV_OFF_IMASK: st_nxt.dat = {30'h0, st_r.imask};
        `EXIV_OFF_PINS: st_nxt.dat = {25'h0, pin_change_inputs, ext_irq_pin};
        default: st_nxt.dat = 32'h0000_0000;
      endcase
    end
    // Sets are applied after the entry and write-one clears so an event in the clear cycle is kept.
    if (det_bus.ext_event) begin
      st_nxt.ext_irq_flag = 1'b1;
      st_nxt.istat[0] = 1'b1;
    end
    if (det_bus.pc_event) begin
      st_nxt.pin_change_flag = 1'b1;
      st_nxt.istat[1] = 1'b1;
    end
    if (det_bus.ext_level) begin
      st_nxt.istat[0] = 1'b1;
    end
    // The flag never holds in level mode.
    if (st_nxt.core_control_reg[1:0] == 2'b00) begin
      st_nxt.ext_irq_flag = 1'b0;
    end
    st_nxt.irq = |(st_nxt.istat & st_nxt.imask);
    // Fixed priority: lower vector address first.
    st_nxt.req = gie & (ext_pending | pc_pending);
    if (ext_pending) begin
      st_nxt.vec = `EXIV_VEC_EXT;
    end else if (pc_pending) begin
      st_nxt.vec = `EXIV_VEC_PC;
    end else begin
      st_nxt.vec = `EXIV_VEC_RESET;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= '{bus: EXIV_BUS_IDLE, dat: 32'h0000_0000, err: 1'b0,
        core_control_reg: `EXIV_RESET_CTRL, ext_en: 1'b0, pc_en: 1'b0,
        ext_irq_flag: 1'b0, pin_change_flag: 1'b0, pin_change_mask: 6'h00,
        istat: 2'h0, imask: 2'h0, req: 1'b0, vec: 4'h0, irq: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = (st_r.bus == EXIV_BUS_ACK);
  assign wb_dat_o = st_r.dat;
  assign wb_err_o = st_r.err;
  assign irq_req = st_r.req;
  assign irq_vector = st_r.vec;
  assign irq_out = st_r.irq;

  // Vectors 3 to 14 belong to other blocks; only 1 and 2 are issued here.
  // Sleep clocking and the start-up wait are outside this block.

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence fall_seen;
    $fell(ext_irq_pin) && sense == 2'b10;
  endsequence

  sequence ext_armed;
    gie && st_r.ext_en;
  endsequence

  sequence pc_armed;
    gie && st_r.pc_en;
  endsequence

  sequence any_seen;
    $changed(ext_irq_pin) && sense == 2'b01;
  endsequence

  sequence pc_toggled;
    |(st_r.pin_change_mask & (pin_change_inputs ^ $past(pin_change_inputs)));
  endsequence

  sequence ext_entry;
    irq_taken && irq_taken_vector == `EXIV_VEC_EXT && !det_bus.ext_event;
  endsequence

  sequence pc_entry;
    irq_taken && irq_taken_vector == `EXIV_VEC_PC && !det_bus.pc_event;
  endsequence

  fall_edge_flag_a: assert property (fall_seen |=> st_r.ext_irq_flag)
    else $error("falling edge did not set flag");
  rise_edge_flag_a: assert property ($rose(ext_irq_pin) && sense == 2'b11
    |=> st_r.ext_irq_flag)
    else $error("rising edge did not set flag");
  level_flag_zero_a: assert property (sense == 2'b00 |=> !st_r.ext_irq_flag)
    else $error("flag set in level mode");
  level_request_a: assert property (gie && st_r.ext_en && sense == 2'b00 && !ext_irq_pin
    |=> irq_req && irq_vector == 4'h1)
    else $error("low level not requested");
  masked_pc_a: assert property (st_r.pin_change_mask == 6'h00 && !st_r.pin_change_flag
    && !(wr && wb_adr_i == `EXIV_OFF_MASK) |=> !st_r.pin_change_flag)
    else $error("unmasked pin change set flag");
  pc_toggle_a: assert property (pc_toggled |=> st_r.pin_change_flag)
    else $error("masked toggle lost");
  no_gie_req_a: assert property (!gie |=> !irq_req)
    else $error("request without global enable");
  pc_vector_a: assert property (irq_req && !$past(st_r.ext_en) |-> irq_vector == 4'h2)
    else $error("pin change vector wrong");

  bus_ack_a: assert property (bus_req |=> wb_ack_o)
    else $error("request not acknowledged");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over two cycles");
  err_unmapped_a: assert property (bus_req && !mapped |=> wb_err_o)
    else $error("unmapped access without error");
  err_mapped_a: assert property (bus_req && mapped |=> !wb_err_o)
    else $error("error on mapped access");
  mask_write_a: assert property (wr && wb_adr_i == `EXIV_OFF_MASK
    |=> st_r.pin_change_mask == $past(wb_dat_i[5:0]))
    else $error("mask write lost");

  any_change_flag_a: assert property (any_seen |=> st_r.ext_irq_flag)
    else $error("pin change in change mode lost");
  rise_no_fall_a: assert property (sense == 2'b11 && $fell(ext_irq_pin)
    && !st_r.ext_irq_flag |=> !st_r.ext_irq_flag)
    else $error("falling edge set flag in rise mode");
  fall_request_a: assert property (fall_seen ##0 ext_armed ##1 ext_armed
    |=> irq_req && irq_vector == 4'h1)
    else $error("falling edge not requested");
  ext_entry_clear_a: assert property (ext_entry |=> !st_r.ext_irq_flag)
    else $error("handler entry kept external flag");
  ext_write_clear_a: assert property (wr && wb_adr_i == `EXIV_OFF_FLAG
    && wb_dat_i[`EXIV_FLAG_EXT] && !det_bus.ext_event |=> !st_r.ext_irq_flag)
    else $error("write one kept external flag");
  level_release_a: assert property (sense == 2'b00 && ext_irq_pin
    && !st_r.pin_change_flag |=> !irq_req)
    else $error("level request without low pin");
  level_istat_a: assert property (det_bus.ext_level |=> st_r.istat[0])
    else $error("low level not recorded in status");

  pc_request_a: assert property (pc_toggled ##0 pc_armed ##1 pc_armed |=> irq_req)
    else $error("pin change not requested");
  pc_quiet_a: assert property (!st_r.pin_change_flag &&
    !(|(st_r.pin_change_mask & (pin_change_inputs ^ $past(pin_change_inputs))))
    |=> !st_r.pin_change_flag)
    else $error("pin change flag set without masked toggle");
  pc_entry_clear_a: assert property (pc_entry |=> !st_r.pin_change_flag)
    else $error("handler entry kept pin change flag");

  istat_read_clear_a: assert property (rd && wb_adr_i == `EXIV_OFF_ISTAT && !det_bus.ext_event
    && !det_bus.ext_level && !det_bus.pc_event |=> st_r.istat == 2'h0 && !irq_out)
    else $error("status read did not clear");
  req_vector_a: assert property (irq_req |-> irq_vector == 4'h1 || irq_vector == 4'h2)
    else $error("request with foreign vector");
  ext_first_a: assert property (ext_pending && pc_pending |=> irq_vector == 4'h1)
    else $error("pin change served before external pin");
  no_source_req_a: assert property (!st_r.ext_en && !st_r.pc_en |=> !irq_req)
    else $error("request with sources disabled");
  pc_enabled_req_a: assert property (pc_armed ##0 st_r.pin_change_flag |=> irq_req)
    else $error("pending pin change not requested");
endmodule

// ===== tb/exiv_pin_model.sv
// Far-side driver that holds the external pin and the pin-change lines.
module exiv_pin_model (
  input wire logic sys_clk,
  output logic ext_pin,
  output logic [5:0] pc_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ext_pin = 1'b1;
    pc_pins = 6'h00;
  end
  // Lines are driven like port outputs and held until changed.
  task automatic set_ext(input logic v);
    @(posedge sys_clk);
    ext_pin <= v;
  endtask
  task automatic flip_pc(input logic [5:0] m);
    @(posedge sys_clk);
    pc_pins <= pc_pins ^ m;
  endtask
endmodule

// ===== tb/external_interrupt_vectors_tb.sv
// Self-checking bench for the interrupt vector controller.
`include "exiv_regs.svh"
module external_interrupt_vectors_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic wb_we_i;
  logic [3:0] wb_sel_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_ack_o;
  logic wb_err_o;
  logic last_err;
  logic ext_irq_pin;
  logic [5:0] pin_change_inputs;
  logic irq_taken;
  logic [3:0] irq_taken_vector;
  logic irq_req;
  logic [3:0] irq_vector;
  logic irq_out;
  int n_fail = 0;
  int checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  exiv_ctrl u_exiv_ctrl (.sys_clk(sys_clk), .reset(reset), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .ext_irq_pin(ext_irq_pin), .pin_change_inputs(pin_change_inputs),
    .irq_taken(irq_taken), .irq_taken_vector(irq_taken_vector), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_out(irq_out));
  exiv_pin_model u_exiv_pin_model (.sys_clk(sys_clk), .ext_pin(ext_irq_pin),
    .pc_pins(pin_change_inputs));
  task automatic conclude();
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk(1'b0, 1'b1, "bus ack");
    rd = wb_dat_o;
    last_err = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wait_req(input logic exp);
    int n;
    n = 0;
    while (irq_req !== exp && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    chk(irq_req, exp, "request");
  endtask
  task automatic take(input logic [3:0] v);
    irq_taken <= 1'b1;
    irq_taken_vector <= v;
    @(posedge sys_clk);
    irq_taken <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic t_reset();
    wb_sel_i <= 4'hE;
    wb(1'b1, `EXIV_OFF_CTRL, 32'h7);
    wb_sel_i <= 4'hF;
    wb(1'b0, `EXIV_OFF_CTRL, 32'h0);
    chk(rd, {24'h0, `EXIV_RESET_CTRL}, "ctrl reset");
    chk(irq_vector, 4'h0, "idle vector");
    wb(1'b0, 8'h40, 32'h0);
    chk(last_err, 1'b1, "unmapped err");
  endtask
  task automatic t_fall();
    wb(1'b1, `EXIV_OFF_IMASK, 32'h1);
    wb(1'b1, `EXIV_OFF_ENABLE, 32'h60);
    wb(1'b1, `EXIV_OFF_CTRL, 32'h6);
    u_exiv_pin_model.set_ext(1'b0);
    @(posedge sys_clk);
    u_exiv_pin_model.set_ext(1'b1);
    wait_req(1'b1);
    chk(irq_vector, `EXIV_VEC_EXT, "ext vector");
    chk(irq_out, 1'b1, "irq out");
    wb(1'b0, `EXIV_OFF_FLAG, 32'h0);
    chk(rd[6], 1'b1, "ext flag");
    wb(1'b0, `EXIV_OFF_ISTAT, 32'h0);
    chk(rd[0], 1'b1, "istat set");
    chk(irq_out, 1'b0, "irq out cleared");
    wb(1'b0, `EXIV_OFF_ISTAT, 32'h0);
    chk(rd[0], 1'b0, "istat clear on read");
    take(`EXIV_VEC_EXT);
    wait_req(1'b0);
  endtask
  task automatic t_modes();
    wb(1'b1, `EXIV_OFF_CTRL, 32'h5);
    for (int i = 0; i < 2; i++) begin
      u_exiv_pin_model.set_ext(i[0]);
      wait_req(1'b1);
      take(`EXIV_VEC_EXT);
      wait_req(1'b0);
    end
    wb(1'b1, `EXIV_OFF_CTRL, 32'h7);
    u_exiv_pin_model.set_ext(1'b0);
    repeat (6) @(posedge sys_clk);
    chk(irq_req, 1'b0, "no fall in rise mode");
    u_exiv_pin_model.set_ext(1'b1);
    wait_req(1'b1);
    wb(1'b1, `EXIV_OFF_FLAG, 32'h40);
    wait_req(1'b0);
  endtask
  task automatic t_level();
    wb(1'b1, `EXIV_OFF_CTRL, 32'h4);
    u_exiv_pin_model.set_ext(1'b0);
    wait_req(1'b1);
    take(`EXIV_VEC_EXT);
    repeat (4) @(posedge sys_clk);
    chk(irq_req, 1'b1, "level holds");
    wb(1'b0, `EXIV_OFF_FLAG, 32'h0);
    chk(rd[6], 1'b0, "flag zero in level");
    u_exiv_pin_model.set_ext(1'b1);
    wait_req(1'b0);
  endtask
  task automatic t_gie_pc();
    wb(1'b1, `EXIV_OFF_CTRL, 32'h2);
    u_exiv_pin_model.set_ext(1'b0);
    repeat (6) @(posedge sys_clk);
    chk(irq_req, 1'b0, "gie off");
    wb(1'b1, `EXIV_OFF_FLAG, 32'h40);
    wb(1'b1, `EXIV_OFF_CTRL, 32'h6);
    wb(1'b1, `EXIV_OFF_MASK, 32'h04);
    u_exiv_pin_model.flip_pc(6'h01);
    repeat (6) @(posedge sys_clk);
    chk(irq_req, 1'b0, "unmasked pin");
    u_exiv_pin_model.flip_pc(6'h04);
    wait_req(1'b1);
    chk(irq_vector, `EXIV_VEC_PC, "pc vector");
    wb(1'b0, `EXIV_OFF_FLAG, 32'h0);
    chk(rd[5], 1'b1, "pc flag");
    u_exiv_pin_model.set_ext(1'b1);
    u_exiv_pin_model.set_ext(1'b0);
    repeat (3) @(posedge sys_clk);
    chk(irq_vector, `EXIV_VEC_EXT, "ext before pc");
    take(`EXIV_VEC_EXT);
    wb(1'b1, `EXIV_OFF_ENABLE, 32'h20);
    chk(irq_vector, `EXIV_VEC_PC, "pc after ext");
    take(`EXIV_VEC_PC);
    wait_req(1'b0);
  endtask
  initial begin
    reset <= 1'b1;
    wb_adr_i <= 8'h00;
    wb_dat_i <= 32'h0;
    wb_we_i <= 1'b0;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    irq_taken <= 1'b0;
    irq_taken_vector <= 4'h0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_fall();
    t_modes();
    t_level();
    t_gie_pc();
    conclude();
  end
  initial begin
    #100us;
    n_fail++;
    conclude();
  end
endmodule
